// file: hw/cosc_top.sv
// Strap latching, power-down, safe frequency, stop and test mode control
// of a board clock generator, with an APB register slave.
// Assumes control pins are asynchronous; shared pins are read while output disabled.
`timescale 1ns/1ns
module cosc_top
   import cosc_pkg::*;
#(
   parameter int HPW = 8
) (
   input  wire logic        clk_in,           // 100 MHz system clock
   input  wire logic        reset_in,         // Sync reset, active high
   // APB slave
   input  wire logic        psel_in,          // Select
   input  wire logic        penable_in,       // Access phase
   input  wire logic        pwrite_in,        // Write when high
   input  wire logic [7:0]  paddr_in,         // Byte address
   input  wire logic [31:0] pwdata_in,        // Write data
   output logic      [31:0] prdata_out,       // Read data
   output logic             pready_out,       // Transfer done
   output logic             pslverr_out,      // Unmapped address
   // Control pins
   input  wire logic        pwrdwn_n_in,      // Power-down or safe input
   input  wire logic        pci_stop_n_in,    // PCI stop, active low
   input  wire logic        test_n_in,        // Test mode, active low
   input  wire logic        supply_good_n_in, // Strap qualifier
   input  wire logic        cpu_freq_strap_a_in, // CPU strap a
   input  wire logic        cpu_freq_strap_b_in, // CPU strap b
   // Shared strap and clock pins
   input  wire logic        mode_pin_in,      // Mode strap level
   output logic             pci0_out,         // PCI clock copy 0
   output logic             pci0_oe_out,      // Drive enable
   input  wire logic        video_pin_in,     // Video rate strap level
   output logic             video_out,        // Video path clock
   output logic             video_oe_out,     // Drive enable
   input  wire logic        usb_pin_in,       // USB rate strap level
   output logic             usb_out,          // USB clock
   output logic             usb_oe_out,       // Drive enable
   input  wire logic        dot_pin_in,       // Extra strap level
   output logic             display_clock_out, // Display clock
   output logic             display_oe_out,   // Drive enable
   // Dedicated outputs
   output logic             cpu_clk_out,      // CPU clock
   output logic             src_clk_out,      // Serial reference clock
   output logic      [6:1]  pci_clk_out,      // PCI copies 1 to 6
   output logic      [2:0]  free_running_pci_clock_clk_out,     // Free-running PCI clocks
   output logic      [3:1]  mid_rate_clock_out, // Mid-rate copies
   output logic             mid0_out,         // Mid-rate or reset_n
   output logic      [1:0]  cpu_freq_sel_out, // Selected CPU code
   output logic             test_mode_out     // Test mode active
);
   typedef enum logic [1:0] {
      COSC_ST_RESET = 2'b00,
      COSC_ST_LATCH = 2'b01,
      COSC_ST_RUN   = 2'b10
   } cosc_state_t;

   cosc_state_t  state_q;
   logic [3:0]   sync_q;      // pd_n, stop_n, test_n, sg_n
   logic         sg_prev_q;
   logic         sg_fell;
   logic [1:0]   cpu_strap_q;
   logic         video_strap_q, usb_strap_q, extra_strap_q, mode_strap_q;
   logic [1:0]   ctrl_q;
   logic         pd_active, safe_mode, pci_stopped, test_mode;
   logic [HPW-1:0] hp [COSC_NCLK];
   logic [COSC_NCLK-1:0] stop, clk;
   logic         strap_done;

   if (HPW < 5) begin : g_chk
      $error("cosc_top: HPW too small for the half period tables");
   end

   // Half period of the CPU clock for a strap code
   function automatic logic [7:0] cpu_hp(input logic [1:0] sel);
      case (sel)
         2'h0:    cpu_hp = COSC_HP_CPU0;
         2'h1:    cpu_hp = COSC_HP_CPU1;
         2'h2:    cpu_hp = COSC_HP_CPU2;
         default: cpu_hp = COSC_HP_CPU3;
      endcase
   endfunction

   // Resynchronise control inputs
   cosc_sync #(.W(4), .RST_VAL(8'h0F)) u_sync (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .d_in     ({supply_good_n_in, test_n_in, pci_stop_n_in, pwrdwn_n_in}),
      .q_out    (sync_q)
   );

   // Pin function decode
   assign pd_active   = !ctrl_q[COSC_CTRL_FSEL] && !sync_q[0];
   assign safe_mode   = ctrl_q[COSC_CTRL_FSEL] && !sync_q[0];
   assign pci_stopped = !sync_q[1];
   assign test_mode   = !sync_q[2];
   assign sg_fell     = sg_prev_q && !sync_q[3];
   assign strap_done  = (state_q == COSC_ST_RUN);

   // Startup sequence: read shared pins with drivers off, then run
   always_ff @(posedge clk_in) begin
      if (reset_in)
         state_q <= COSC_ST_RESET;
      else begin
         case (state_q)
            COSC_ST_RESET: state_q <= COSC_ST_LATCH;
            COSC_ST_LATCH: state_q <= COSC_ST_RUN;
            default:       state_q <= COSC_ST_RUN;
         endcase
      end
   end

   // Shared pin straps latched once, held afterwards
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         video_strap_q <= 1'b0;
         usb_strap_q   <= 1'b0;
         extra_strap_q <= 1'b0;
         mode_strap_q  <= 1'b0;
      end else if (state_q == COSC_ST_LATCH) begin
         video_strap_q <= video_pin_in;
         usb_strap_q   <= usb_pin_in;
         extra_strap_q <= dot_pin_in;
         mode_strap_q  <= mode_pin_in;
      end
   end

   // CPU straps: startup and supply good falling edge
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cpu_strap_q <= 2'h0;
         sg_prev_q   <= 1'b1;
      end else begin
         sg_prev_q <= sync_q[3];
         if (state_q == COSC_ST_LATCH || sg_fell)
            cpu_strap_q <= {cpu_freq_strap_b_in, cpu_freq_strap_a_in};
      end
   end

   // Selected CPU code, safe mode overrides straps
   always_ff @(posedge clk_in) begin
      if (reset_in)
         cpu_freq_sel_out <= 2'h0;
      else
         cpu_freq_sel_out <= safe_mode ? COSC_CPU_SAFE_SEL : cpu_strap_q;
   end

   // Half period tables, test mode divides the reference
   always_comb begin
      hp[COSC_I_CPU]   = HPW'(cpu_hp(cpu_freq_sel_out));
      hp[COSC_I_SRC]   = HPW'(COSC_HP_SRC);
      hp[COSC_I_PCI]   = HPW'(COSC_HP_PCI);
      hp[COSC_I_FREE_RUNNING_PCI_CLOCK]  = HPW'(COSC_HP_PCI);
      hp[COSC_I_MID]   = HPW'(COSC_HP_MID);
      hp[COSC_I_VIDEO] = HPW'(video_strap_q ? COSC_HP_48 : COSC_HP_MID);
      hp[COSC_I_USB]   = HPW'(usb_strap_q ? COSC_HP_24 : COSC_HP_48);
      hp[COSC_I_DOT]   = HPW'(COSC_HP_48);
      if (test_mode) begin
         hp[COSC_I_CPU]   = HPW'(COSC_HP_TDIV2);
         hp[COSC_I_SRC]   = HPW'(COSC_HP_TDIV2);
         hp[COSC_I_PCI]   = HPW'(COSC_HP_TDIV8);
         hp[COSC_I_FREE_RUNNING_PCI_CLOCK]  = HPW'(COSC_HP_TDIV8);
         hp[COSC_I_MID]   = HPW'(COSC_HP_TDIV4);
         hp[COSC_I_VIDEO] = HPW'(COSC_HP_TDIV4);
         hp[COSC_I_USB]   = HPW'(COSC_HP_TDIV2);
         hp[COSC_I_DOT]   = HPW'(COSC_HP_TDIV2);
      end
   end

   // Stop requests: power-down stops all, PCI stop only PCI and SRC
   always_comb begin
      stop = {COSC_NCLK{pd_active || !strap_done}};
      stop[COSC_I_PCI] = stop[COSC_I_PCI] || pci_stopped;
      stop[COSC_I_SRC] = stop[COSC_I_SRC] || pci_stopped;
   end

   // One divider per clock group, parking low without short pulses
   for (genvar i = 0; i < COSC_NCLK; i++) begin : g_div
      cosc_clk_div #(.HPW(HPW)) u_div (
         .clk_in         (clk_in),
         .reset_in       (reset_in),
         .half_period_in (hp[i]),
         .stop_in        (stop[i]),
         .clk_out        (clk[i])
      );
   end

   // Registered pin outputs and drive enables
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cpu_clk_out        <= 1'b0;
         src_clk_out        <= 1'b0;
         pci_clk_out        <= 6'h00;
         pci0_out           <= 1'b0;
         free_running_pci_clock_clk_out       <= 3'h0;
         mid_rate_clock_out <= 3'h0;
         mid0_out           <= 1'b0;
         video_out          <= 1'b0;
         usb_out            <= 1'b0;
         display_clock_out  <= 1'b0;
         pci0_oe_out        <= 1'b0;
         video_oe_out       <= 1'b0;
         usb_oe_out         <= 1'b0;
         display_oe_out     <= 1'b0;
         test_mode_out      <= 1'b0;
      end else begin
         cpu_clk_out        <= clk[COSC_I_CPU];
         src_clk_out        <= clk[COSC_I_SRC];
         pci_clk_out        <= {6{clk[COSC_I_PCI]}};
         pci0_out           <= clk[COSC_I_PCI];
         free_running_pci_clock_clk_out       <= {3{clk[COSC_I_FREE_RUNNING_PCI_CLOCK]}};
         mid_rate_clock_out <= {3{clk[COSC_I_MID]}};
         mid0_out           <= mode_strap_q ? !ctrl_q[COSC_CTRL_WDRST]
                                            : clk[COSC_I_MID];
         video_out          <= clk[COSC_I_VIDEO];
         usb_out            <= clk[COSC_I_USB];
         display_clock_out  <= clk[COSC_I_DOT];
         pci0_oe_out        <= strap_done;
         video_oe_out       <= strap_done;
         usb_oe_out         <= strap_done;
         display_oe_out     <= strap_done;
         test_mode_out      <= test_mode;
      end
   end

   // Control register write at the access edge
   always_ff @(posedge clk_in) begin
      if (reset_in)
         ctrl_q <= COSC_CTRL_RST;
      else if (psel_in && penable_in && pready_out && pwrite_in &&
               paddr_in == COSC_CTRL_OFS)
         ctrl_q <= pwdata_in[1:0];
   end

   // APB answer prepared in the setup cycle, zero wait states
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end else begin
         pready_out  <= psel_in && !penable_in;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         if (psel_in && !penable_in) begin
            if (paddr_in == COSC_CTRL_OFS)
               prdata_out <= {30'h0, ctrl_q};
            else if (paddr_in == COSC_STATUS_OFS)
               prdata_out <= {22'h0, test_mode, safe_mode, pd_active,
                              sync_q[1], mode_strap_q, extra_strap_q,
                              usb_strap_q, video_strap_q,
                              cpu_strap_q};
            else
               pslverr_out <= 1'b1;
         end
      end
   end

   // Checks
   property p_fsel_pd;
      @(posedge clk_in) disable iff (reset_in)
      (ctrl_q[COSC_CTRL_FSEL] && strap_done) |-> !stop[COSC_I_MID];
   endproperty
   a_fsel_pd: assert property (p_fsel_pd) else $error("power-down in safe mode");

   property p_pd_park;
      @(posedge clk_in) disable iff (reset_in)
      (pd_active && !clk[COSC_I_CPU]) |=> !clk[COSC_I_CPU];
   endproperty
   a_pd_park: assert property (p_pd_park) else $error("clock rose in power-down");

   property p_safe_sel;
      @(posedge clk_in) disable iff (reset_in)
      safe_mode |=> cpu_freq_sel_out == COSC_CPU_SAFE_SEL;
   endproperty
   a_safe_sel: assert property (p_safe_sel) else $error("safe code not used");

   property p_mid0_clk;
      @(posedge clk_in) disable iff (reset_in)
      (strap_done && !mode_strap_q) |=> mid0_out == $past(clk[COSC_I_MID]);
   endproperty
   a_mid0_clk: assert property (p_mid0_clk) else $error("shared pin wrong");

   property p_cpu_recap;
      @(posedge clk_in) disable iff (reset_in)
      sg_fell |=> cpu_strap_q ==
         $past({cpu_freq_strap_b_in, cpu_freq_strap_a_in});
   endproperty
   a_cpu_recap: assert property (p_cpu_recap) else $error("strap not caught");

   property p_status_rd;
      @(posedge clk_in) disable iff (reset_in)
      (psel_in && !penable_in && !pwrite_in && paddr_in == COSC_STATUS_OFS)
      |=> pready_out && prdata_out[1:0] == $past(cpu_strap_q);
   endproperty
   a_status_rd: assert property (p_status_rd) else $error("status wrong");

   property p_pci_park;
      @(posedge clk_in) disable iff (reset_in)
      (pci_stopped && !clk[COSC_I_PCI]) ##1 pci_stopped
      |-> !clk[COSC_I_PCI] [*2];
   endproperty
   a_pci_park: assert property (p_pci_park) else $error("PCI ran in stop");

   property p_test_div2;
      @(posedge clk_in) disable iff (reset_in)
      (test_mode && !pd_active && strap_done) [*4] ##0 !clk[COSC_I_CPU]
      |=> clk[COSC_I_CPU];
   endproperty
   a_test_div2: assert property (p_test_div2) else $error("test rate wrong");

   property p_strap_hold;
      @(posedge clk_in) disable iff (reset_in)
      strap_done |=> $stable({video_strap_q, usb_strap_q, mode_strap_q});
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

   c_pd:   cover property (@(posedge clk_in) disable iff (reset_in) pd_active);
   c_safe: cover property (@(posedge clk_in) disable iff (reset_in) safe_mode);
   c_free_running_pci_clock: cover property (@(posedge clk_in) disable iff (reset_in)
                           pci_stopped && $rose(clk[COSC_I_FREE_RUNNING_PCI_CLOCK]));
   c_test: cover property (@(posedge clk_in) disable iff (reset_in)
                           test_mode && $rose(clk[COSC_I_MID]));
endmodule

// file: hw/cosc_pkg.sv
// Constants, register map and clock model tables of the clock control block.
// Assumes a 100 MHz system clock; clock rates are modelled as half periods.
package cosc_pkg;
   // APB register offsets (byte addresses)
   localparam logic [7:0]  COSC_CTRL_OFS   = 8'h00;
   localparam logic [7:0]  COSC_STATUS_OFS = 8'h04;
   // Control register fields
   localparam int          COSC_CTRL_FSEL  = 0;   // Pin function select
   localparam int          COSC_CTRL_WDRST = 1;   // Drive reset output low
   localparam logic [1:0]  COSC_CTRL_RST   = 2'h0;
   // Status register fields
   localparam int          COSC_ST_CPU     = 0;   // Two bits, a then b
   localparam int          COSC_ST_VIDEO   = 2;
   localparam int          COSC_ST_USB     = 3;
   localparam int          COSC_ST_EXTRA   = 4;
   localparam int          COSC_ST_MODE    = 5;
   localparam int          COSC_ST_PSTOP   = 6;
   localparam int          COSC_ST_PDOWN   = 7;
   localparam int          COSC_ST_SAFE    = 8;
   localparam int          COSC_ST_TEST    = 9;
   // Predefined safe CPU selection
   localparam logic [1:0]  COSC_CPU_SAFE_SEL = 2'h0;
   // Model half periods in system clock cycles, normal mode
   localparam logic [7:0]  COSC_HP_CPU0    = 8'h06;  // Strap code 0
   localparam logic [7:0]  COSC_HP_CPU1    = 8'h03;  // Strap code 1
   localparam logic [7:0]  COSC_HP_CPU2    = 8'h05;  // Strap code 2
   localparam logic [7:0]  COSC_HP_CPU3    = 8'h04;  // Strap code 3
   localparam logic [7:0]  COSC_HP_SRC     = 8'h06;
   localparam logic [7:0]  COSC_HP_MID     = 8'h09;  // 66.66 MHz model
   localparam logic [7:0]  COSC_HP_48      = 8'h0C;  // 48 MHz model
   localparam logic [7:0]  COSC_HP_24      = 8'h18;  // 24 MHz model
   localparam logic [7:0]  COSC_HP_PCI     = 8'h12;  // 33 MHz model
   // Test mode half periods: divide by two, four and eight
   localparam logic [7:0]  COSC_HP_TDIV2   = 8'h01;
   localparam logic [7:0]  COSC_HP_TDIV4   = 8'h02;
   localparam logic [7:0]  COSC_HP_TDIV8   = 8'h04;
   // Clock generator indices
   localparam int          COSC_NCLK       = 8;
   localparam int          COSC_I_CPU      = 0;
   localparam int          COSC_I_SRC      = 1;
   localparam int          COSC_I_PCI      = 2;
   localparam int          COSC_I_FREE_RUNNING_PCI_CLOCK     = 3;
   localparam int          COSC_I_MID      = 4;
   localparam int          COSC_I_VIDEO    = 5;
   localparam int          COSC_I_USB      = 6;
   localparam int          COSC_I_DOT      = 7;
endpackage

// file: hw/cosc_sync.sv
// Two flip-flop level synchroniser for a vector of control inputs.
// Assumes inputs are quasi-static levels; reset value is a constant.
`timescale 1ns/1ns
module cosc_sync #(
   parameter int         W       = 1,
   parameter logic [7:0] RST_VAL = 8'hFF
) (
   input  wire logic         clk_in,    // System clock
   input  wire logic         reset_in,  // Sync reset, active high
   input  wire logic [W-1:0] d_in,      // Asynchronous levels
   output logic      [W-1:0] q_out      // Synchronised levels
);
   logic [W-1:0] meta_q;

   if (W < 1 || W > 8) begin : g_chk
      $error("cosc_sync: W must be 1 to 8");
   end

   // First stage feeds only the second
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         meta_q <= RST_VAL[W-1:0];
         q_out  <= RST_VAL[W-1:0];
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end
endmodule

// file: hw/cosc_clk_div.sv
// Divider producing one modelled output clock with a glitch-free stop.
// Assumes the half period input is at least one and changes rarely.
`timescale 1ns/1ns
module cosc_clk_div #(
   parameter int HPW = 8
) (
   input  wire logic           clk_in,         // System clock
   input  wire logic           reset_in,       // Sync reset, active high
   input  wire logic [HPW-1:0] half_period_in, // Cycles per half period
   input  wire logic           stop_in,        // Park low when high
   output logic                clk_out         // Modelled clock level
);
   logic [HPW-1:0] cnt_q;
   logic           tick;

   if (HPW < 2) begin : g_chk
      $error("cosc_clk_div: HPW must be at least 2");
   end

   assign tick = (cnt_q >= half_period_in - HPW'(1));

   // Half period counter
   always_ff @(posedge clk_in) begin
      if (reset_in)
         cnt_q <= '0;
      else if (tick)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + HPW'(1);
   end

   // High phase always completes; stop only blocks the next rise
   always_ff @(posedge clk_in) begin
      if (reset_in)
         clk_out <= 1'b0;
      else if (tick) begin
         if (clk_out)
            clk_out <= 1'b0;
         else if (!stop_in)
            clk_out <= 1'b1;
      end
   end
endmodule

// file: verification/cosc_far_end.sv
// Far side model: board logic driving the control and strap pins.
// Assumes the bench sets intents; shared pins read back driven levels.
`timescale 1ns/1ns
module cosc_far_end (
   input  wire logic       clk_in,    // System clock, unused by levels
   input  wire logic [3:0] ctl_n_in,  // Intent {test,stop,pd,good}
   input  wire logic [5:0] strap_in,  // Intent {b,a,dot,usb,vid,mode}
   input  wire logic [3:0] oe_in,     // Enables {dot,usb,vid,mode}
   input  wire logic [3:0] drv_in,    // Levels {dot,usb,vid,mode}
   output logic      [3:0] ctl_n_out, // Control pins
   output logic      [1:0] fs_out,    // CPU strap pins {b,a}
   output logic      [3:0] pin_out    // Shared pin levels
);
   // Control pins follow the intent, which moves just after an edge
   assign ctl_n_out = ctl_n_in;
   // CPU straps frozen while supply good is low
   always_latch begin
      if (ctl_n_in[0]) begin
         fs_out = strap_in[5:4];
      end
   end
   // Device level when it drives the pin, strap level otherwise
   assign pin_out = (oe_in & drv_in) | (~oe_in & strap_in[3:0]);
endmodule

// file: verification/cosc_top_tb.sv
// Bench of the clock control block: straps, stops, test mode, APB.
// Assumes the far side model drives every control and strap pin.
`timescale 1ns/1ns
module cosc_top_tb
   import cosc_pkg::*;
;
   logic clk_in, reset_in, psel_in, penable_in, pwrite_in, err;
   logic [7:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   logic pready_out, pslverr_out, pci0_out, pci0_oe_out, video_out;
   logic video_oe_out, usb_out, usb_oe_out, display_clock_out;
   logic display_oe_out, cpu_clk_out, src_clk_out, mid0_out;
   logic test_mode_out;
   wire pwrdwn_n_in, pci_stop_n_in, test_n_in, supply_good_n_in;
   wire cpu_freq_strap_a_in, cpu_freq_strap_b_in;
   wire mode_pin_in, video_pin_in, usb_pin_in, dot_pin_in;
   logic [6:1] pci_clk_out;
   logic [2:0] free_running_pci_clock_clk_out;
   logic [3:1] mid_rate_clock_out;
   logic [1:0] cpu_freq_sel_out;
   logic [3:0] ctl_n;
   logic [5:0] strap;
   logic [17:0] all_clk;
   int num_errors, compares, cycles;

   cosc_top dut_u (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
      .pwrdwn_n_in, .pci_stop_n_in, .test_n_in, .supply_good_n_in,
      .cpu_freq_strap_a_in, .cpu_freq_strap_b_in, .mode_pin_in, .pci0_out,
      .pci0_oe_out, .video_pin_in, .video_out, .video_oe_out, .usb_pin_in,
      .usb_out, .usb_oe_out, .dot_pin_in, .display_clock_out,
      .display_oe_out, .cpu_clk_out, .src_clk_out, .pci_clk_out,
      .free_running_pci_clock_clk_out, .mid_rate_clock_out, .mid0_out, .cpu_freq_sel_out,
      .test_mode_out);
   cosc_far_end far_u (.clk_in, .ctl_n_in(ctl_n), .strap_in(strap),
      .oe_in({display_oe_out, usb_oe_out, video_oe_out, pci0_oe_out}),
      .drv_in({display_clock_out, usb_out, video_out, pci0_out}),
      .ctl_n_out({test_n_in, pci_stop_n_in, pwrdwn_n_in, supply_good_n_in}),
      .fs_out({cpu_freq_strap_b_in, cpu_freq_strap_a_in}),
      .pin_out({dot_pin_in, usb_pin_in, video_pin_in, mode_pin_in}));

   // Every clock output except mid0_out; low byte is what the PCI stop parks
   assign all_clk = {free_running_pci_clock_clk_out, cpu_clk_out, mid_rate_clock_out,
      video_out, usb_out, display_clock_out, src_clk_out, pci_clk_out,
      pci0_out};

   // Clock and hang guard
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         results();
      end
   end

   task automatic results();
      if (num_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer; pready sampled at the rising edge that ends it
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= wd;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // Counts rising edges of one clock over n cycles, allows one of slack
   task automatic rises(input int sel, input int n, input int hp);
      int c;
      logic p, v;
      c = 0;
      p = 1'b0;
      repeat (n) begin
         @(posedge clk_in);
         case (sel)
            0: v = cpu_clk_out;
            1: v = mid_rate_clock_out[1];
            2: v = free_running_pci_clock_clk_out[0];
            3: v = video_out;
            5: v = mid0_out;
            default: v = usb_out;
         endcase
         if (v === 1'b1 && p === 1'b0) c++;
         p = v;
      end
      chk(32'(c > n / (2 * hp) - 2 && c < n / (2 * hp) + 2), 1, "rate");
   endtask

   // Checks that masked clocks stay low for n cycles
   task automatic parked(input logic [17:0] m, input int n);
      repeat (40) @(posedge clk_in);
      repeat (n) begin
         @(posedge clk_in);
         chk(32'(all_clk & m), 0, "parked");
      end
   endtask

   task automatic t_straps();
      apb(0, COSC_STATUS_OFS, 0);
      chk(rd, 32'h75, "straps");
      chk(cpu_freq_sel_out, 2'h1, "cpu sel");
      rises(0, 120, COSC_HP_CPU1);
      rises(3, 192, COSC_HP_48);
      rises(4, 192, COSC_HP_48);
      rises(1, 180, COSC_HP_MID);
      strap <= 6'b100100;
      repeat (10) @(posedge clk_in);
      apb(0, COSC_STATUS_OFS, 0);
      chk(rd, 32'h75, "held");
   endtask

   task automatic t_regs();
      apb(1, COSC_CTRL_OFS, 32'h2);
      repeat (4) @(posedge clk_in);
      chk(mid0_out, 0, "reset out");
      apb(0, COSC_CTRL_OFS, 0);
      chk(rd, 32'h2, "ctrl");
      apb(1, 8'h08, 32'h3);
      chk(err, 1, "unmapped wr");
      apb(0, 8'h08, 0);
      chk(err, 1, "unmapped rd err");
      chk(rd, 0, "unmapped rd data");
      apb(1, COSC_STATUS_OFS, 32'h3FF);
      chk(err, 0, "ro write");
      apb(1, COSC_CTRL_OFS, 0);
      repeat (4) @(posedge clk_in);
      chk(mid0_out, 1, "reset released");
   endtask

   task automatic t_sg();
      ctl_n[0] <= 1'b0;
      repeat (8) @(posedge clk_in);
      chk(cpu_freq_sel_out, 2'h2, "recapture");
      ctl_n[0] <= 1'b1;
      rises(0, 100, COSC_HP_CPU2);
   endtask

   task automatic t_pd();
      ctl_n[1] <= 1'b0;
      parked(18'h3FFFF, 40);
      apb(0, COSC_STATUS_OFS, 0);
      chk(rd, 32'hF6, "pd status");
      apb(1, COSC_CTRL_OFS, 32'h1);
      repeat (8) @(posedge clk_in);
      chk(cpu_freq_sel_out, COSC_CPU_SAFE_SEL, "safe");
      rises(0, 120, COSC_HP_CPU0);
      ctl_n[1] <= 1'b1;
      apb(1, COSC_CTRL_OFS, 0);
   endtask

   task automatic t_stop();
      ctl_n[2] <= 1'b0;
      parked(18'h000FF, 40);
      rises(2, 144, COSC_HP_PCI);
      ctl_n[2] <= 1'b1;
   endtask

   task automatic t_test();
      ctl_n[3] <= 1'b0;
      repeat (10) @(posedge clk_in);
      chk(test_mode_out, 1, "test mode");
      rises(0, 64, COSC_HP_TDIV2);
      rises(1, 64, COSC_HP_TDIV4);
      rises(2, 64, COSC_HP_TDIV8);
      ctl_n[3] <= 1'b1;
   endtask

   // Second reset with the other strap levels: clock on shared pin
   task automatic t_reset();
      strap <= 6'b000100;
      reset_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      apb(0, COSC_STATUS_OFS, 0);
      chk(rd, 32'h48, "restrap");
      rises(5, 180, COSC_HP_MID);
      rises(3, 180, COSC_HP_MID);
      rises(4, 192, COSC_HP_24);
      rises(0, 120, COSC_HP_CPU0);
   endtask

   // Main sequence
   initial begin
      cycles = 0;
      num_errors = 0;
      compares = 0;
      reset_in = 1'b1;
      {psel_in, penable_in, pwrite_in} = 3'h0;
      paddr_in = 8'h00;
      pwdata_in = 32'h0;
      ctl_n = 4'hF;
      strap = 6'b011011;
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      t_straps();
      t_regs();
      t_sg();
      t_pd();
      t_stop();
      t_test();
      t_reset();
      results();
   end
endmodule
